// >>> common/fskds_pkg.sv
// shared constants and types for the fsk deviation selector
package fskds_pkg;
   // ----------------------------------------
   // widths and sizes
   // ----------------------------------------
   localparam int STEP_W   = 16;   // signed deviation step count width
   localparam int NUM_W    = 24;   // fractional numerator width
   localparam int SLOTS    = 8;    // deviation slots per profile
   localparam int IDX_W    = 3;    // slot index width
   localparam int PROFILES = 2;    // frequency profiles
   localparam int LVL_W    = 2;    // symbol level count field width

   // ----------------------------------------
   // reset values
   // ----------------------------------------
   localparam logic [STEP_W-1:0] STEP_RST = 16'h0000;
   localparam logic [NUM_W-1:0]  NUM_RST  = 24'h00_0000;
   localparam logic [IDX_W-1:0]  IDX_RST  = 3'h0;

   // ----------------------------------------
   // source modes, order matches {sel_hi, sel_lo}
   // ----------------------------------------
   typedef enum logic [1:0] {
      FSKDS_PIN,
      FSKDS_INDEX,
      FSKDS_AUDIO,
      FSKDS_FAST
   } fskds_mode_t;
endpackage

// >>> common/fskds_aud_if.sv
// carrier for received audio-stream step words
`timescale 1ns/1ps
interface fskds_aud_if;
   logic [fskds_pkg::STEP_W-1:0] word;
   logic                         valid;

   modport src (output word, output valid);
   modport snk (input word, input valid);
endinterface

// >>> hdl/fskds_audio_rx.sv
// serial audio stream receiver producing step words
`timescale 1ns/1ps
module fskds_audio_rx (
   input  wire logic   clk_sys,
   input  wire logic   rst,
   input  wire logic   aud_bclk,
   input  wire logic   aud_lrclk,
   input  wire logic   aud_data,
   fskds_aud_if.src    aud
);
   typedef struct packed {
      logic                         armed;
      logic                         bclk_q;
      logic                         lr_q;
      logic [fskds_pkg::STEP_W-1:0] shreg;
      logic [fskds_pkg::STEP_W-1:0] word;
      logic                         valid;
   } fskds_aud_state_t;

   fskds_aud_state_t q_r;
   fskds_aud_state_t q_nxt;

   // shift msb first on bclk rise, frame word on any lrclk change
   // only the last STEP_W bits of a slot survive; longer slots are truncated
   always_comb begin
      q_nxt        = q_r;
      q_nxt.bclk_q = aud_bclk;
      q_nxt.lr_q   = aud_lrclk;
      q_nxt.valid  = 1'b0;
      q_nxt.armed  = 1'b1;
      // first cycle after reset only samples the pins: a pin resting high
      // would otherwise look like an edge against the cleared history
      if (q_r.armed && aud_bclk && !q_r.bclk_q) begin
         q_nxt.shreg = {q_r.shreg[fskds_pkg::STEP_W-2:0], aud_data};
      end
      if (q_r.armed && aud_lrclk != q_r.lr_q) begin
         q_nxt.word  = q_r.shreg;
         q_nxt.valid = 1'b1;
      end
   end

   // state register
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         q_r <= '0;
      end else begin
         q_r <= q_nxt;
      end
   end

   assign aud.word  = q_r.word;
   assign aud.valid = q_r.valid;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   property p_aud_frame;
      @(posedge clk_sys) disable iff (rst)
      (q_r.armed && aud_lrclk != q_r.lr_q)
      |=> (q_r.valid && q_r.word == $past(q_r.shreg));
   endproperty
   a_aud_frame: assert property (p_aud_frame)
      else $error("audio word not framed on lrclk edge");

   property p_aud_shift;
      @(posedge clk_sys) disable iff (rst)
      (q_r.armed && aud_bclk && !q_r.bclk_q) |=> (q_r.shreg[0] == $past(aud_data));
   endproperty
   a_aud_shift: assert property (p_aud_shift)
      else $error("audio bit not shifted on bclk rise");
endmodule

// >>> hdl/fskds_top.sv
// fsk deviation selector: slot lookup, direct and streamed step words
`timescale 1ns/1ps
module fskds_top #(
   parameter int STEP_W = fskds_pkg::STEP_W,
   parameter int NUM_W  = fskds_pkg::NUM_W
) (
   input  wire logic                          clk_sys,
   input  wire logic                          rst,
   input  wire logic                          mod_source_sel_hi,
   input  wire logic                          mod_source_sel_lo,
   input  wire logic [fskds_pkg::LVL_W-1:0]   symbol_level_count,
   input  wire logic                          profile_sel,
   input  wire logic                          profile1_modulation_on,
   input  wire logic                          profile2_modulation_on,
   input  wire logic                          slot_wr_en,
   input  wire logic                          slot_wr_profile,
   input  wire logic [fskds_pkg::IDX_W-1:0]   slot_wr_idx,
   input  wire logic [STEP_W-1:0]             slot_wr_data,
   input  wire logic                          index_wr_en,
   input  wire logic [fskds_pkg::IDX_W-1:0]   deviation_index_write,
   input  wire logic                          direct_wr_en,
   input  wire logic [STEP_W-1:0]             direct_step_word,
   input  wire logic [fskds_pkg::IDX_W-1:0]   mod_pins,
   input  wire logic                          aud_bclk,
   input  wire logic                          aud_lrclk,
   input  wire logic                          aud_data,
   input  wire logic [NUM_W-1:0]              nominal_num,
   output logic      [NUM_W-1:0]              frac_num_r,
   output logic      [STEP_W-1:0]             dev_offset_r,
   output logic                               mod_active_r
);
   // ----------------------------------------
   // state
   // ----------------------------------------
   typedef struct packed {
      logic [fskds_pkg::PROFILES-1:0][fskds_pkg::SLOTS-1:0][STEP_W-1:0] slots;
      logic [fskds_pkg::IDX_W-1:0]                                     idx;
      logic [STEP_W-1:0]                                               fast;
      logic [STEP_W-1:0]                                               offset;
      logic [NUM_W-1:0]                                                num;
      logic                                                            active;
   } fskds_state_t;

   fskds_state_t          q_r;
   fskds_state_t          q_nxt;
   fskds_pkg::fskds_mode_t mode;
   logic [fskds_pkg::IDX_W-1:0] lvl_mask;
   logic                  prof_on;
   logic [STEP_W-1:0]     dev_sel;

   fskds_aud_if aud_bus ();

   // ----------------------------------------
   // audio stream receiver
   // ----------------------------------------
   fskds_audio_rx fskds_audio_rx_i (
      .clk_sys   (clk_sys),
      .rst       (rst),
      .aud_bclk  (aud_bclk),
      .aud_lrclk (aud_lrclk),
      .aud_data  (aud_data),
      .aud       (aud_bus.src)
   );

   // ----------------------------------------
   // decode
   // ----------------------------------------
   // mode decode from the two select bits
   // select decode
   assign mode = fskds_pkg::fskds_mode_t'({mod_source_sel_hi, mod_source_sel_lo});
   // level mask: count 2 keeps two index bits, i.e. four levels
   // level masking
   assign lvl_mask = 3'((4'h1 << symbol_level_count) - 4'h1);
   assign prof_on = profile_sel ? profile2_modulation_on : profile1_modulation_on;

   // slot lookup for pin/index, held direct or streamed word otherwise
   // slot lookup
   always_comb begin
      if (mode == fskds_pkg::FSKDS_PIN || mode == fskds_pkg::FSKDS_INDEX) begin
         dev_sel = q_r.slots[profile_sel][q_r.idx];
      end else begin
         dev_sel = q_r.fast;
      end
   end

   // next state: one stage of selection, then numerator sum
   always_comb begin
      q_nxt = q_r;
      if (slot_wr_en) begin
         q_nxt.slots[slot_wr_profile][slot_wr_idx] = slot_wr_data;
      end
      case (mode)
         fskds_pkg::FSKDS_PIN: begin
            q_nxt.idx = mod_pins & lvl_mask;
         end
         fskds_pkg::FSKDS_INDEX: begin
            if (index_wr_en) begin
               q_nxt.idx = deviation_index_write & lvl_mask;
            end
         end
         fskds_pkg::FSKDS_AUDIO: begin
            if (aud_bus.valid) begin
               q_nxt.fast = aud_bus.word;
            end
         end
         fskds_pkg::FSKDS_FAST: begin
            if (direct_wr_en) begin
               q_nxt.fast = direct_step_word;
            end
         end
         default: begin
            q_nxt.idx = q_r.idx;
         end
      endcase
      q_nxt.active = prof_on;
      q_nxt.offset = prof_on ? dev_sel : fskds_pkg::STEP_RST;
      // signed offset sign-extended onto the numerator; wraps modulo 2^NUM_W
      // step equals numerator unit
      q_nxt.num = NUM_W'(nominal_num + {{(NUM_W-STEP_W){q_nxt.offset[STEP_W-1]}}, q_nxt.offset});
   end

   // state register
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         q_r <= '0;
      end else begin
         q_r <= q_nxt;
      end
   end

   // outputs straight from the state flops
   assign frac_num_r   = q_r.num;
   assign dev_offset_r = q_r.offset;
   assign mod_active_r = q_r.active;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   property p_step;
      @(posedge clk_sys) disable iff (rst)
      1'b1 |=> frac_num_r == NUM_W'($past(nominal_num)
               + {{(NUM_W-STEP_W){dev_offset_r[STEP_W-1]}}, dev_offset_r});
   endproperty
   a_step: assert property (p_step)
      else $error("numerator not nominal plus offset");

   property p_neg;
      @(posedge clk_sys) disable iff (rst)
      (nominal_num[NUM_W-1:STEP_W] != '0 && q_nxt.offset[STEP_W-1])
      |=> frac_num_r < $past(nominal_num);
   endproperty
   a_neg: assert property (p_neg)
      else $error("negative offset did not lower numerator");

   property p_slot;
      @(posedge clk_sys) disable iff (rst)
      (prof_on && (mode == fskds_pkg::FSKDS_PIN || mode == fskds_pkg::FSKDS_INDEX))
      |=> dev_offset_r == $past(q_r.slots[profile_sel][q_r.idx]);
   endproperty
   a_slot: assert property (p_slot)
      else $error("slot deviation not applied");

   property p_index;
      @(posedge clk_sys) disable iff (rst)
      (mode == fskds_pkg::FSKDS_INDEX && index_wr_en && symbol_level_count == 2'h3
       && prof_on) ##1 prof_on && mode == fskds_pkg::FSKDS_INDEX && !slot_wr_en
      |=> dev_offset_r == $past(q_r.slots[profile_sel][q_r.idx])
          && $past(q_r.idx) == $past(deviation_index_write, 2);
   endproperty
   a_index: assert property (p_index)
      else $error("index write did not apply slot");

   property p_pins;
      @(posedge clk_sys) disable iff (rst)
      mode == fskds_pkg::FSKDS_PIN |=> q_r.idx == $past(mod_pins & lvl_mask);
   endproperty
   a_pins: assert property (p_pins)
      else $error("pin index not taken");

   property p_four;
      @(posedge clk_sys) disable iff (rst)
      // only cycles that load the index; stale indices in other modes are legal
      (symbol_level_count == 2'h2 && (mode == fskds_pkg::FSKDS_PIN
       || (mode == fskds_pkg::FSKDS_INDEX && index_wr_en))) |=> !q_r.idx[2];
   endproperty
   a_four: assert property (p_four)
      else $error("four-level index exceeds range");

   property p_off;
      @(posedge clk_sys) disable iff (rst)
      !prof_on |=> (!mod_active_r && dev_offset_r == fskds_pkg::STEP_RST);
   endproperty
   a_off: assert property (p_off)
      else $error("deviation applied while profile disabled");

   property p_fast;
      @(posedge clk_sys) disable iff (rst)
      (mode == fskds_pkg::FSKDS_FAST && direct_wr_en)
      ##1 (mode == fskds_pkg::FSKDS_FAST && !direct_wr_en && prof_on)
      |=> dev_offset_r == $past(direct_step_word, 2);
   endproperty
   a_fast: assert property (p_fast)
      else $error("direct step word not applied");

   property p_hold;
      @(posedge clk_sys) disable iff (rst)
      (mode == fskds_pkg::FSKDS_PIN || mode == fskds_pkg::FSKDS_INDEX) |=> $stable(q_r.fast);
   endproperty
   a_hold: assert property (p_hold)
      else $error("direct word changed in slot modes");

   property p_stream;
      @(posedge clk_sys) disable iff (rst)
      (mode == fskds_pkg::FSKDS_AUDIO && aud_bus.valid) |=> q_r.fast == $past(aud_bus.word);
   endproperty
   a_stream: assert property (p_stream)
      else $error("audio word not taken");

   property p_mask;
      @(posedge clk_sys) disable iff (rst)
      mode == fskds_pkg::FSKDS_PIN |=> (q_r.idx & ~$past(lvl_mask)) == '0;
   endproperty
   a_mask: assert property (p_mask)
      else $error("index outside level range");
endmodule

// >>> verification/fskds_host_model.sv
// host-side model streaming step words over the audio pins
`timescale 1ns/1ps
module fskds_host_model (
   input  wire logic clk_sys,
   output logic      aud_bclk,
   output logic      aud_lrclk,
   output logic      aud_data
);
   // pins at rest; bit clock stands still outside frames
   initial begin
      aud_bclk = 1'b0;
      aud_lrclk = 1'b0;
      aud_data = 1'b0;
   end

   // scaled signed sample sent
   // msb first, bit clock low for two system cycles and high for three (two on the last bit)
   task automatic send_word(input logic [fskds_pkg::STEP_W-1:0] w);
      for (int i = fskds_pkg::STEP_W - 1; i >= 0; i--) begin
         @(negedge clk_sys);
         aud_data = w[i];
         aud_bclk = 1'b0;
         repeat (2) @(negedge clk_sys);
         aud_bclk = 1'b1;
         repeat (2) @(negedge clk_sys);
      end
      aud_bclk = 1'b0;
      repeat (2) @(negedge clk_sys);
      aud_lrclk = ~aud_lrclk;
      // released data must not keep the last bit
      aud_data = ~w[0];
   endtask
endmodule

// >>> verification/test_fskds_top.sv
// self-checking bench for the fsk deviation selector
`timescale 1ns/1ps
module test_fskds_top;
   typedef struct packed {
      logic [1:0] m;
      logic       p;
      logic [1:0] l;
      logic [2:0] x;
      logic [2:0] s;
   } fskds_row_t;
   // mode, profile, level count, pin or index value, expected slot
   localparam fskds_row_t ROWS [9] = '{
      '{2'h0, 1'b0, 2'h3, 3'h5, 3'h5}, '{2'h0, 1'b0, 2'h2, 3'h7, 3'h3},
      '{2'h0, 1'b1, 2'h1, 3'h6, 3'h0}, '{2'h0, 1'b1, 2'h0, 3'h7, 3'h0},
      '{2'h1, 1'b0, 2'h2, 3'h2, 3'h2}, '{2'h1, 1'b0, 2'h2, 3'h3, 3'h3},
      '{2'h1, 1'b1, 2'h3, 3'h7, 3'h7}, '{2'h1, 1'b1, 2'h1, 3'h1, 3'h1},
      '{2'h1, 1'b0, 2'h3, 3'h4, 3'h4}};
   logic        clk_sys = 1'b0;
   logic        rst = 1'b1;
   logic [1:0]  mode = 2'h0;
   logic [1:0]  lvl = 2'h0;
   logic        prof = 1'b0;
   logic        on1 = 1'b1;
   logic        on2 = 1'b1;
   logic        swe = 1'b0;
   logic        swp = 1'b0;
   logic [2:0]  swi = 3'h0;
   logic [15:0] swd = 16'h0000;
   logic        iwe = 1'b0;
   logic [2:0]  iwv = 3'h0;
   logic        dwe = 1'b0;
   logic [15:0] dwv = 16'h0000;
   logic [2:0]  pins = 3'h0;
   logic [23:0] nom = 24'h12_3456;
   logic        bclk;
   logic        lrclk;
   logic        adat;
   logic [23:0] frac;
   logic [15:0] dev;
   logic        act;
   logic [15:0] e;
   int          fail_count = 0;
   int          checked = 0;
   int          n;

   always #2 clk_sys = ~clk_sys;

   fskds_top fskds_top_i (.clk_sys(clk_sys), .rst(rst), .mod_source_sel_hi(mode[1]),
      .mod_source_sel_lo(mode[0]), .symbol_level_count(lvl), .profile_sel(prof),
      .profile1_modulation_on(on1), .profile2_modulation_on(on2), .slot_wr_en(swe),
      .slot_wr_profile(swp), .slot_wr_idx(swi), .slot_wr_data(swd), .index_wr_en(iwe),
      .deviation_index_write(iwv), .direct_wr_en(dwe), .direct_step_word(dwv),
      .mod_pins(pins), .aud_bclk(bclk), .aud_lrclk(lrclk), .aud_data(adat),
      .nominal_num(nom), .frac_num_r(frac), .dev_offset_r(dev), .mod_active_r(act));

   fskds_host_model fskds_host_model_i (.clk_sys(clk_sys), .aud_bclk(bclk),
      .aud_lrclk(lrclk), .aud_data(adat));

   // slot contents: upper half of each profile holds negative swings
   function automatic logic [15:0] slot_val(input logic p, input logic [2:0] i);
      logic [15:0] v;
      v = 16'h0200 + {7'h00, p, 5'h00, i};
      return i[2] ? -v : v;
   endfunction

   // ----------------------------------------
   // compare and report
   // ----------------------------------------
   task automatic chk_step(input string nm, input logic [15:0] ex, input logic [15:0] s);
      checked++;
      if (s !== ex) begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", nm, ex, s);
      end
   endtask

   task automatic chk_num(input logic [23:0] ex);
      checked++;
      if (frac !== ex) begin
         fail_count++;
         $display("MISMATCH frac_num_r expected %h seen %h", ex, frac);
      end
   endtask

   task automatic chk_flag(input logic ex);
      checked++;
      if (act !== ex) begin
         fail_count++;
         $display("MISMATCH mod_active_r expected %b seen %b", ex, act);
      end
   endtask

   task automatic conclude;
      $display("checked %0d fail_count %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      repeat (2) @(negedge clk_sys);
      chk_step("reset offset", 16'h0000, dev);
      chk_num(24'h00_0000);
      @(negedge clk_sys);
      rst = 1'b0;
      // preload both profiles, back to back writes
      for (int i = 0; i < 16; i++) begin
         swe = 1'b1;
         swp = i[3];
         swi = i[2:0];
         swd = slot_val(i[3], i[2:0]);
         @(negedge clk_sys);
      end
      swe = 1'b0;
      // table cases: pin mode and index mode
      foreach (ROWS[k]) begin
         mode = ROWS[k].m;
         prof = ROWS[k].p;
         lvl = ROWS[k].l;
         pins = ROWS[k].x;
         iwv = ROWS[k].x;
         iwe = (ROWS[k].m == 2'h1);
         @(negedge clk_sys);
         iwe = 1'b0;
         repeat (3) @(negedge clk_sys);
         e = slot_val(ROWS[k].p, ROWS[k].s);
         chk_step("slot offset", e, dev);
         chk_num(nom + {{8{e[15]}}, e});
         chk_flag(1'b1);
      end
      // fast mode: back to back writes, last one wins
      mode = 2'h3;
      dwe = 1'b1;
      dwv = 16'hFDFA;
      @(negedge clk_sys);
      dwv = 16'hFAB3;
      @(negedge clk_sys);
      dwe = 1'b0;
      // an index write here must not cause a slot lookup
      iwe = 1'b1;
      iwv = 3'h2;
      @(negedge clk_sys);
      iwe = 1'b0;
      repeat (3) @(negedge clk_sys);
      chk_step("fast offset", 16'hFAB3, dev);
      chk_num(nom + 24'hFF_FAB3);
      // disabled profile drops the offset
      on1 = 1'b0;
      repeat (3) @(negedge clk_sys);
      chk_step("disabled offset", 16'h0000, dev);
      chk_flag(1'b0);
      chk_num(nom);
      on1 = 1'b1;
      // profile two follows its own enable, not profile one's
      prof = 1'b1;
      on2 = 1'b0;
      repeat (3) @(negedge clk_sys);
      chk_step("profile two off", 16'h0000, dev);
      chk_flag(1'b0);
      on2 = 1'b1;
      repeat (3) @(negedge clk_sys);
      chk_step("profile two on", 16'hFAB3, dev);
      chk_flag(1'b1);
      prof = 1'b0;
      // audio stream mode, bounded wait for the word to land
      mode = 2'h2;
      fskds_host_model_i.send_word(16'h068E);
      for (n = 0; n < 40 && dev !== 16'h068E; n++)
         @(negedge clk_sys);
      chk_step("audio offset", 16'h068E, dev);
      // second reset mid-run, frame clock left high: no false word after it
      rst = 1'b1;
      @(negedge clk_sys);
      chk_step("mid reset offset", 16'h0000, dev);
      chk_num(24'h00_0000);
      chk_flag(1'b0);
      rst = 1'b0;
      repeat (2) @(negedge clk_sys);
      chk_step("post reset offset", 16'h0000, dev);
      chk_num(nom);
      chk_flag(1'b1);
      conclude();
   end
endmodule
